// file: hw/cpc_counter.v
// Purpose: parameter set and 32-bit up/down counter with compare and status
// Assumes: parameters written by the head station while the module is stopped
// Notes: control word bits act on their rising edges only
`include "cpc_regs.vh"
module cpc_counter #(
	parameter CLK_HZ = `CPC_CLK_HZ
) (
	input wire clk_sys,
	input wire reset,
	input wire pin_track_a,
	input wire pin_track_b,
	input wire pin_reset_in,
	input wire prm_wr,
	input wire [3:0] prm_slot,
	input wire [31:0] prm_wdata,
	input wire [31:0] compare_value,
	input wire [31:0] set_value,
	input wire [15:0] ctrl_word,
	input wire [3:0] irq_ack,
	output reg [31:0] prm_rdata_reg,
	output reg [31:0] counter_value_reg,
	output reg [15:0] status_reg,
	output reg compare_output_flag,
	output reg [3:0] irq_pending_reg,
	output reg diag_alarm_on_reg
);
	// ----------------------------------------
	// Parameter set
	// ----------------------------------------
	reg [7:0] diag_alarm_enable, track_a_filter_select, track_b_filter_select;
	reg [7:0] reset_input_filter, process_irq_enables, count_function_select;
	reg [7:0] compare_reset_mode, evaluation_gate_mode, compare_hysteresis_band;
	reg [31:0] count_limit_value, count_start_value;
	always @(posedge clk_sys) begin
		if (reset) begin
			diag_alarm_enable <= `CPC_RST_BYTE;
			track_a_filter_select <= `CPC_RST_FILT;
			track_b_filter_select <= `CPC_RST_FILT;
			reset_input_filter <= `CPC_RST_FILT;
			process_irq_enables <= `CPC_RST_BYTE;
			count_function_select <= `CPC_RST_BYTE;
			compare_reset_mode <= `CPC_RST_BYTE;
			evaluation_gate_mode <= `CPC_RST_BYTE;
			compare_hysteresis_band <= `CPC_RST_BYTE;
			count_limit_value <= `CPC_RST_WORD;
			count_start_value <= `CPC_RST_WORD;
		end else if (prm_wr) begin
			case (prm_slot)
			`CPC_SLOT_DIAG: diag_alarm_enable <= prm_wdata[7:0];
			`CPC_SLOT_FILT_A: track_a_filter_select <= prm_wdata[7:0];
			`CPC_SLOT_FILT_B: track_b_filter_select <= prm_wdata[7:0];
			`CPC_SLOT_IRQ: process_irq_enables <= prm_wdata[7:0] & `CPC_IRQ_MASK;
			`CPC_SLOT_FUNC: count_function_select <= prm_wdata[7:0] & `CPC_FUNC_MASK;
			`CPC_SLOT_MODE2: compare_reset_mode <= prm_wdata[7:0] & `CPC_MODE2_MASK;
			`CPC_SLOT_MODE3: evaluation_gate_mode <= prm_wdata[7:0] & `CPC_MODE3_MASK;
			`CPC_SLOT_END: count_limit_value <= prm_wdata;
			`CPC_SLOT_LOAD: count_start_value <= prm_wdata;
			`CPC_SLOT_HYST: compare_hysteresis_band <= prm_wdata[7:0];
			default: reset_input_filter <= `CPC_RST_FILT;
			endcase
		end
	end
	always @(posedge clk_sys) begin
		if (reset) begin
			prm_rdata_reg <= `CPC_RST_WORD;
			diag_alarm_on_reg <= 1'b0;
		end else begin
			diag_alarm_on_reg <= (diag_alarm_enable == `CPC_DIAG_ON);
			case (prm_slot)
			`CPC_SLOT_DIAG: prm_rdata_reg <= {24'h000000, diag_alarm_enable};
			`CPC_SLOT_FILT_A: prm_rdata_reg <= {24'h000000, track_a_filter_select};
			`CPC_SLOT_FILT_B: prm_rdata_reg <= {24'h000000, track_b_filter_select};
			`CPC_SLOT_FILT_R: prm_rdata_reg <= {24'h000000, reset_input_filter};
			`CPC_SLOT_IRQ: prm_rdata_reg <= {24'h000000, process_irq_enables};
			`CPC_SLOT_FUNC: prm_rdata_reg <= {24'h000000, count_function_select};
			`CPC_SLOT_MODE2: prm_rdata_reg <= {24'h000000, compare_reset_mode};
			`CPC_SLOT_MODE3: prm_rdata_reg <= {24'h000000, evaluation_gate_mode};
			`CPC_SLOT_END: prm_rdata_reg <= count_limit_value;
			`CPC_SLOT_LOAD: prm_rdata_reg <= count_start_value;
			`CPC_SLOT_HYST: prm_rdata_reg <= {24'h000000, compare_hysteresis_band};
			default: prm_rdata_reg <= `CPC_RST_WORD;
			endcase
		end
	end
	// ----------------------------------------
	// Inputs and evaluation
	// ----------------------------------------
	wire flt_a, flt_b, flt_r, cnt_up, cnt_dn;
	cpc_filter #(.CLK_HZ(CLK_HZ)) u_flt_a (.clk_sys(clk_sys), .reset(reset),
		.pin(pin_track_a), .freq_sel(track_a_filter_select), .level_reg(flt_a));
	cpc_filter #(.CLK_HZ(CLK_HZ)) u_flt_b (.clk_sys(clk_sys), .reset(reset),
		.pin(pin_track_b), .freq_sel(track_b_filter_select), .level_reg(flt_b));
	cpc_filter #(.CLK_HZ(CLK_HZ)) u_flt_r (.clk_sys(clk_sys), .reset(reset),
		.pin(pin_reset_in), .freq_sel(reset_input_filter), .level_reg(flt_r));
	cpc_eval u_eval (.clk_sys(clk_sys), .reset(reset), .trk_a(flt_a), .trk_b(flt_b),
		.eval_mode(evaluation_gate_mode[2:0]), .invert_b(compare_reset_mode[3]),
		.up_reg(cnt_up), .dn_reg(cnt_dn));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Signed distance test; 33 bits so no wrap at the range ends
	function far_from;
		input [31:0] a;
		input [31:0] b;
		input [7:0] h;
		reg signed [32:0] d;
		begin
			d = $signed({a[31], a}) - $signed({b[31], b});
			if (d < 0)
				d = -d;
			far_from = (h <= 8'h01) ? (d != 0) : (d > $signed({25'h0, h}));
		end
	endfunction
	function sgn_ge;
		input [31:0] a;
		input [31:0] b;
		begin
			sgn_ge = $signed(a) >= $signed(b);
		end
	endfunction
	// ----------------------------------------
	// Control word edges
	// ----------------------------------------
	reg [15:0] cw_old_reg;
	wire [15:0] cw_rise = ctrl_word & ~cw_old_reg;
	reg sync_on_reg, cmp_on_reg, sw_gate_reg, auto_closed_reg, sync_done_reg, rst_old_reg;
	wire counter_off = (evaluation_gate_mode[2:0] == `CPC_EV_OFF);
	wire gate_int = sw_gate_reg & ~auto_closed_reg & ~counter_off;
	wire [2:0] rmode = compare_reset_mode[6:4];
	wire rst_rise = flt_r & ~rst_old_reg;
	reg rst_hit;
	always @* begin
		rst_hit = 1'b0;
		if (sync_on_reg && !counter_off) begin
			case (rmode)
			`CPC_RM_LEVEL: rst_hit = flt_r;
			`CPC_RM_EDGE: rst_hit = rst_rise;
			`CPC_RM_ONCE: rst_hit = rst_rise & ~sync_done_reg;
			default: rst_hit = 1'b0;
			endcase
		end
	end
	// Gate reopen with abort mode reloads; a once-mode auto stop also reloads
	wire gate_reopen = cw_rise[`CPC_CW_GATE_OPEN] & ~gate_int;
	always @(posedge clk_sys) begin
		if (reset) begin
			cw_old_reg <= 16'h0000;
			sync_on_reg <= 1'b0;
			cmp_on_reg <= 1'b0;
			sw_gate_reg <= 1'b0;
			sync_done_reg <= 1'b0;
			rst_old_reg <= 1'b0;
		end else begin
			cw_old_reg <= ctrl_word;
			rst_old_reg <= flt_r;
			if (cw_rise[`CPC_CW_SYNC_ON])
				sync_on_reg <= 1'b1;
			else if (cw_rise[`CPC_CW_SYNC_OFF])
				sync_on_reg <= 1'b0;
			if (cw_rise[`CPC_CW_CMP_ON])
				cmp_on_reg <= 1'b1;
			else if (cw_rise[`CPC_CW_CMP_OFF])
				cmp_on_reg <= 1'b0;
			if (cw_rise[`CPC_CW_GATE_OPEN])
				sw_gate_reg <= 1'b1;
			else if (cw_rise[`CPC_CW_GATE_CLOSE])
				sw_gate_reg <= 1'b0;
			if (rst_hit)
				sync_done_reg <= 1'b1;
			else if (cw_rise[`CPC_CW_SYNC_ON])
				sync_done_reg <= 1'b0;
		end
	end
	// ----------------------------------------
	// Counter
	// ----------------------------------------
	wire [5:0] fn = count_function_select[5:0];
	wire once_mode = (fn == `CPC_FN_ONCE_FWD) | (fn == `CPC_FN_ONCE_BWD) |
		(fn == `CPC_FN_ONCE_NONE);
	wire fwd_mode = (fn == `CPC_FN_ONCE_FWD) | (fn == `CPC_FN_PER_FWD);
	wire bwd_mode = (fn == `CPC_FN_ONCE_BWD) | (fn == `CPC_FN_PER_BWD);
	wire [31:0] cv = counter_value_reg;
	reg [31:0] cv_next;
	reg ev_end, ev_ovf, ev_unf, close_now;
	always @* begin
		cv_next = cv;
		ev_end = 1'b0;
		ev_ovf = 1'b0;
		ev_unf = 1'b0;
		close_now = 1'b0;
		if (counter_off) begin
			cv_next = cv;
		end else if (rst_hit) begin
			cv_next = count_start_value;
		end else if (cw_rise[`CPC_CW_SET_VAL]) begin
			cv_next = set_value;
		end else if (gate_reopen && (!evaluation_gate_mode[7] || auto_closed_reg)) begin
			cv_next = count_start_value;
		end else if (gate_int && cnt_up) begin
			if (fwd_mode && cv == count_limit_value - 32'h0000_0001) begin
				cv_next = count_start_value;
				ev_end = 1'b1;
				close_now = once_mode;
			end else begin
				cv_next = cv + 32'h0000_0001;
				if (cv == `CPC_WMAX && !bwd_mode) begin
					ev_ovf = 1'b1;
					close_now = once_mode;
				end
			end
		end else if (gate_int && cnt_dn) begin
			if (bwd_mode && cv == count_limit_value + 32'h0000_0001) begin
				cv_next = count_start_value;
				ev_end = 1'b1;
				close_now = once_mode;
			end else begin
				cv_next = cv - 32'h0000_0001;
				if (cv == `CPC_WMIN && !fwd_mode) begin
					ev_unf = 1'b1;
					close_now = once_mode;
				end
			end
		end
	end
	always @(posedge clk_sys) begin
		if (reset) begin
			counter_value_reg <= `CPC_RST_WORD;
			auto_closed_reg <= 1'b0;
		end else begin
			counter_value_reg <= cv_next;
			if (close_now)
				auto_closed_reg <= 1'b1;
			else if (cw_rise[`CPC_CW_GATE_OPEN])
				auto_closed_reg <= 1'b0;
		end
	end
	// ----------------------------------------
	// Compare and hysteresis
	// ----------------------------------------
	wire [7:0] hy = compare_hysteresis_band;
	wire [2:0] cmode = compare_reset_mode[2:0];
	reg cmp_cond, cmp_next;
	always @* begin
		cmp_next = compare_output_flag;
		case (cmode)
		`CPC_CMP_GE: begin
			cmp_cond = sgn_ge(cv, compare_value);
			if (!cmp_cond && far_from(cv, compare_value, hy))
				cmp_next = 1'b0;
		end
		`CPC_CMP_LE: begin
			cmp_cond = sgn_ge(compare_value, cv);
			if (!cmp_cond && far_from(cv, compare_value, hy))
				cmp_next = 1'b0;
		end
		`CPC_CMP_EQ: begin
			cmp_cond = (cv == compare_value);
			if (far_from(cv, compare_value, hy))
				cmp_next = 1'b0;
		end
		default: begin
			cmp_cond = 1'b0;
			cmp_next = 1'b0;
		end
		endcase
		if (cmp_cond)
			cmp_next = 1'b1;
		if (!cmp_on_reg || counter_off)
			cmp_next = 1'b0;
	end
	// Re-arm only once the value leaves the band, so jitter raises one event
	reg ovf_arm_reg, unf_arm_reg, zero_arm_reg;
	wire ev_zero = zero_arm_reg && cv == `CPC_RST_WORD && !counter_off;
	wire ev_ovf_h = ev_ovf & ovf_arm_reg;
	wire ev_unf_h = ev_unf & unf_arm_reg;
	wire ev_cmp = cmp_next & ~compare_output_flag;
	always @(posedge clk_sys) begin
		if (reset) begin
			compare_output_flag <= 1'b0;
			ovf_arm_reg <= 1'b1;
			unf_arm_reg <= 1'b1;
			zero_arm_reg <= 1'b1;
		end else begin
			compare_output_flag <= cmp_next;
			if (ev_ovf)
				ovf_arm_reg <= 1'b0;
			else if (far_from(cv, `CPC_WMIN, hy))
				ovf_arm_reg <= 1'b1;
			if (ev_unf)
				unf_arm_reg <= 1'b0;
			else if (far_from(cv, `CPC_WMAX, hy))
				unf_arm_reg <= 1'b1;
			if (ev_zero)
				zero_arm_reg <= 1'b0;
			else if (far_from(cv, `CPC_RST_WORD, hy))
				zero_arm_reg <= 1'b1;
		end
	end
	// ----------------------------------------
	// Sticky status and interrupt requests
	// ----------------------------------------
	reg cmp_st_reg, end_st_reg, ovf_st_reg, unf_st_reg, zero_st_reg;
	wire clr = cw_rise[`CPC_CW_STICKY_CLR];
	wire [3:0] irq_ev = {ev_end, ev_cmp, ev_unf_h, ev_ovf_h};
	always @(posedge clk_sys) begin
		if (reset) begin
			cmp_st_reg <= 1'b0;
			end_st_reg <= 1'b0;
			ovf_st_reg <= 1'b0;
			unf_st_reg <= 1'b0;
			zero_st_reg <= 1'b0;
			irq_pending_reg <= 4'h0;
			status_reg <= 16'h0000;
		end else begin
			// Set wins over a clear in the same cycle
			cmp_st_reg <= ev_cmp | (cmp_st_reg & ~clr);
			end_st_reg <= ev_end | (end_st_reg & ~clr);
			ovf_st_reg <= ev_ovf_h | (ovf_st_reg & ~clr);
			unf_st_reg <= ev_unf_h | (unf_st_reg & ~clr);
			zero_st_reg <= ev_zero | (zero_st_reg & ~clr);
			irq_pending_reg <= (irq_ev & process_irq_enables[5:2]) |
				(irq_pending_reg & ~irq_ack);
			status_reg <= {2'b00, zero_st_reg, unf_st_reg, ovf_st_reg, end_st_reg,
				cmp_st_reg, cnt_up & gate_int, cnt_dn & gate_int, compare_output_flag,
				gate_int, 1'b0, flt_r, sw_gate_reg, cmp_on_reg, sync_done_reg};
		end
	end
endmodule // cpc_counter

// file: hw/cpc_eval.v
// Purpose: turns filtered tracks A and B into count pulses
// Assumes: inputs already filtered and synchronous
// Notes: one pulse per counted edge, forward on up_reg, backward on dn_reg, swapped when invert_b is set
`include "cpc_regs.vh"
module cpc_eval (
	input wire clk_sys,
	input wire reset,
	input wire trk_a,
	input wire trk_b,
	input wire [2:0] eval_mode,
	input wire invert_b,
	output reg up_reg,
	output reg dn_reg
);
	reg a_old_reg, b_old_reg;
	reg hit, fwd;
	always @* begin
		hit = 1'b0;
		fwd = 1'b0;
		case (eval_mode)
		`CPC_EV_SINGLE: begin
			hit = trk_a & ~a_old_reg;
			fwd = ~trk_b;
		end
		`CPC_EV_DOUBLE: begin
			hit = trk_a ^ a_old_reg;
			fwd = trk_a ^ trk_b;
		end
		`CPC_EV_QUAD: begin
			hit = (trk_a ^ a_old_reg) | (trk_b ^ b_old_reg);
			fwd = (trk_a ^ a_old_reg) ? (trk_a ^ trk_b) : ~(trk_a ^ trk_b);
		end
		`CPC_EV_PULSE: begin
			hit = trk_a & ~a_old_reg;
			fwd = ~trk_b;
		end
		default: hit = 1'b0;
		endcase
	end
	always @(posedge clk_sys) begin
		if (reset) begin
			a_old_reg <= 1'b0;
			b_old_reg <= 1'b0;
			up_reg <= 1'b0;
			dn_reg <= 1'b0;
		end else begin
			a_old_reg <= trk_a;
			b_old_reg <= trk_b;
			up_reg <= hit & (fwd ^ invert_b);
			dn_reg <= hit & ~(fwd ^ invert_b);
		end
	end
endmodule // cpc_eval

// file: hw/cpc_filter.v
// Purpose: pin synchroniser and glitch filter for one counter input
// Assumes: pin is asynchronous to clk_sys
// Notes: a level must stay stable for half a period of the corner frequency
`include "cpc_regs.vh"
module cpc_filter #(
	parameter CLK_HZ = `CPC_CLK_HZ
) (
	input wire clk_sys,
	input wire reset,
	input wire pin,
	input wire [7:0] freq_sel,
	output reg level_reg
);
	reg s1_reg, s2_reg, s3_reg;
	reg [31:0] cnt_reg;
	reg [31:0] lim;
	// Unknown codes fall back to 100 kHz; writing them is the host's fault
	always @* begin
		case (freq_sel)
		8'h00: lim = CLK_HZ / (2 * `CPC_F_500K);
		8'h01: lim = CLK_HZ / (2 * `CPC_F_300K);
		8'h03: lim = CLK_HZ / (2 * `CPC_F_60K);
		8'h04: lim = CLK_HZ / (2 * `CPC_F_30K);
		8'h06: lim = CLK_HZ / (2 * `CPC_F_10K);
		8'h07: lim = CLK_HZ / (2 * `CPC_F_5K);
		8'h08: lim = CLK_HZ / (2 * `CPC_F_2K);
		8'h09: lim = CLK_HZ / (2 * `CPC_F_1K);
		default: lim = CLK_HZ / (2 * `CPC_F_100K);
		endcase
	end
	always @(posedge clk_sys) begin
		s1_reg <= pin;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
		if (reset) begin
			cnt_reg <= 32'h0000_0000;
			level_reg <= 1'b0;
		end else if (s2_reg == s3_reg && s3_reg != level_reg) begin
			if (cnt_reg + 32'h0000_0001 >= lim) begin
				level_reg <= s3_reg;
				cnt_reg <= 32'h0000_0000;
			end else begin
				cnt_reg <= cnt_reg + 32'h0000_0001;
			end
		end else begin
			cnt_reg <= 32'h0000_0000;
		end
	end
endmodule // cpc_filter

// file: hw/cpc_regs.vh
// Purpose: constants of the counter parameter block
// Assumes: 100 MHz module clock
// Notes: parameter slots are numbered 01h..0Dh as the head station sends them
`ifndef CPC_REGS_VH
`define CPC_REGS_VH
// ----------------------------------------
// Parameter slots
// ----------------------------------------
`define CPC_SLOT_DIAG 4'h1
`define CPC_SLOT_FILT_A 4'h2
`define CPC_SLOT_FILT_B 4'h3
`define CPC_SLOT_FILT_R 4'h4
`define CPC_SLOT_SPARE_F 4'h5
`define CPC_SLOT_IRQ 4'h6
`define CPC_SLOT_FUNC 4'h7
`define CPC_SLOT_MODE2 4'h8
`define CPC_SLOT_MODE3 4'h9
`define CPC_SLOT_END 4'hA
`define CPC_SLOT_LOAD 4'hB
`define CPC_SLOT_HYST 4'hC
`define CPC_SLOT_SPARE_C 4'hD
// ----------------------------------------
// Reset values, writable masks and diag alarm enable code
// ----------------------------------------
`define CPC_RST_BYTE 8'h00
`define CPC_RST_FILT 8'h02
`define CPC_RST_WORD 32'h0000_0000
`define CPC_DIAG_ON 8'h40
`define CPC_IRQ_MASK 8'h3C
`define CPC_FUNC_MASK 8'h3F
`define CPC_MODE2_MASK 8'h7F
`define CPC_MODE3_MASK 8'h87
// ----------------------------------------
// Field codes
// ----------------------------------------
`define CPC_FN_ONCE_FWD 6'h01
`define CPC_FN_ONCE_BWD 6'h02
`define CPC_FN_ONCE_NONE 6'h04
`define CPC_FN_PER_FWD 6'h08
`define CPC_FN_PER_BWD 6'h10
`define CPC_FN_PER_NONE 6'h20
`define CPC_CMP_GE 3'h1
`define CPC_CMP_LE 3'h2
`define CPC_CMP_EQ 3'h4
`define CPC_RM_LEVEL 3'h1
`define CPC_RM_EDGE 3'h3
`define CPC_RM_ONCE 3'h5
`define CPC_EV_OFF 3'h0
`define CPC_EV_SINGLE 3'h1
`define CPC_EV_DOUBLE 3'h2
`define CPC_EV_QUAD 3'h3
`define CPC_EV_PULSE 3'h4
// ----------------------------------------
// Control word bits
// ----------------------------------------
`define CPC_CW_SYNC_ON 0
`define CPC_CW_CMP_ON 1
`define CPC_CW_GATE_OPEN 2
`define CPC_CW_SET_VAL 5
`define CPC_CW_STICKY_CLR 6
`define CPC_CW_SYNC_OFF 8
`define CPC_CW_CMP_OFF 9
`define CPC_CW_GATE_CLOSE 10
// ----------------------------------------
// Clock and filter corner frequencies in Hz, counter range ends
// ----------------------------------------
`define CPC_CLK_HZ 100000000
`define CPC_F_500K 500000
`define CPC_F_300K 300000
`define CPC_F_100K 100000
`define CPC_F_60K 60000
`define CPC_F_30K 30000
`define CPC_F_10K 10000
`define CPC_F_5K 5000
`define CPC_F_2K 2000
`define CPC_F_1K 1000
`define CPC_WMAX 32'h7FFF_FFFF
`define CPC_WMIN 32'h8000_0000
`endif

// file: test/cpc_counter_properties.sv
// Purpose: concurrent checks on the counter parameter block ports
// Assumes: one clock, synchronous active-high reset
// Notes: control bits act on rising edges, so helpers keep short windows
module cpc_counter_properties (
	input wire clk_sys,
	input wire reset,
	input wire prm_wr,
	input wire [3:0] prm_slot,
	input wire [31:0] prm_wdata,
	input wire [15:0] ctrl_word,
	input wire [3:0] irq_ack,
	input wire [31:0] prm_rdata_reg,
	input wire [15:0] status_reg,
	input wire compare_output_flag,
	input wire [3:0] irq_pending_reg,
	input wire diag_alarm_on_reg
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	logic [15:0] ctrl_reg;
	logic [3:0] irq_en_reg;
	logic cmp_seen_reg;
	logic sync_seen_reg;
	logic [2:0] open_cnt_reg;
	logic [2:0] clr_cnt_reg;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Window of four cycles covers the lag of status_reg
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl_reg <= 16'h0000;
			irq_en_reg <= 4'h0;
			cmp_seen_reg <= 1'b0;
			sync_seen_reg <= 1'b0;
			open_cnt_reg <= 3'h0;
			clr_cnt_reg <= 3'h0;
		end else begin
			ctrl_reg <= ctrl_word;
			if (prm_wr && prm_slot == 4'h6) begin
				irq_en_reg <= prm_wdata[5:2];
			end
			cmp_seen_reg <= cmp_seen_reg | ctrl_word[1];
			sync_seen_reg <= sync_seen_reg | ctrl_word[0];
			open_cnt_reg <= (ctrl_word[2] & ~ctrl_reg[2]) ? 3'h4 : open_cnt_reg - {2'h0, |open_cnt_reg};
			clr_cnt_reg <= (ctrl_word[6] & ~ctrl_reg[6]) ? 3'h4 : clr_cnt_reg - {2'h0, |clr_cnt_reg};
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Byte lands on the write edge, the enable output follows one edge later
	a_diag_follows_byte: assert property (prm_wr && prm_slot == 4'h1 |=> ##1
		diag_alarm_on_reg == ($past(prm_wdata[7:0], 2) == 8'h40))
		else $error("diag enable wrong");
	a_irq_needs_enable: assert property (
		(irq_pending_reg & ~$past(irq_pending_reg) & ~$past(irq_en_reg)) == 4'h0)
		else $error("interrupt raised while disabled");
	a_irq_held_until_ack: assert property (
		($past(irq_pending_reg) & ~$past(irq_ack) & ~irq_pending_reg) == 4'h0)
		else $error("interrupt request dropped without ack");
	a_cmp_needs_enable: assert property (!cmp_seen_reg |-> !compare_output_flag)
		else $error("compare flag without compare enable");
	a_sync_needs_enable: assert property (!sync_seen_reg |-> !status_reg[0])
		else $error("reset input acted without reset mode");
	a_gate_opens_on_rise: assert property ($rose(status_reg[2]) |-> open_cnt_reg != 3'h0)
		else $error("gate opened without control edge");
	a_sticky_held: assert property (
		(($past(status_reg[13:9]) & ~status_reg[13:9]) != 5'h00) |-> clr_cnt_reg != 3'h0)
		else $error("sticky flag cleared without clear edge");
	a_load_readback: assert property ((prm_wr && prm_slot == 4'hB) ##1
		(!prm_wr && prm_slot == 4'hB) |=> prm_rdata_reg == $past(prm_wdata, 2))
		else $error("load value readback wrong");
endmodule // cpc_counter_properties

// file: test/cpc_counter_tb_top.sv
// Purpose: self-checking bench for the counter parameter block
// Assumes: CLK_HZ lowered so the 500 kHz filter needs two cycles
// Notes: table rows cover parameter slots; counting cases follow by hand
module cpc_counter_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic pin_reset_in = 1'b0;
	logic prm_wr = 1'b0;
	logic [3:0] prm_slot = 4'h0;
	logic [31:0] prm_wdata = 32'h0;
	logic [31:0] compare_value = 32'h0;
	logic [31:0] set_value = 32'h0;
	logic [15:0] ctrl_word = 16'h0;
	logic [3:0] irq_ack = 4'h0;
	logic fwd = 1'b0;
	logic bwd = 1'b0;
	wire trk_a;
	wire trk_b;
	wire [31:0] prm_rdata_reg;
	wire [31:0] counter_value_reg;
	wire [15:0] status_reg;
	wire compare_output_flag;
	wire [3:0] irq_pending_reg;
	wire diag_alarm_on_reg;
	int fail_count = 0;
	int num_checks = 0;
	logic [31:0] v;
	// Slot, written data, expected readback
	localparam logic [67:0] rows [14] = '{
		{4'h1, 32'h40, 32'h40}, {4'h2, 32'h0, 32'h0}, {4'h3, 32'h0, 32'h0},
		{4'h4, 32'h9, 32'h2}, {4'h5, 32'hFF, 32'h0}, {4'h6, 32'hFF, 32'h3C},
		{4'h7, 32'hFF, 32'h3F}, {4'h8, 32'hFF, 32'h7F}, {4'h9, 32'hFF, 32'h87},
		{4'hA, 32'h8000_0000, 32'h8000_0000}, {4'hB, 32'h1234, 32'h1234},
		{4'hC, 32'hFF, 32'hFF}, {4'hD, 32'hFF, 32'h0}, {4'hE, 32'hFF, 32'h0}};
	cpc_counter #(.CLK_HZ(2000000)) uut (
		.clk_sys(clk_sys), .reset(reset), .pin_track_a(trk_a), .pin_track_b(trk_b),
		.pin_reset_in(pin_reset_in), .prm_wr(prm_wr), .prm_slot(prm_slot),
		.prm_wdata(prm_wdata), .compare_value(compare_value), .set_value(set_value),
		.ctrl_word(ctrl_word), .irq_ack(irq_ack), .prm_rdata_reg(prm_rdata_reg),
		.counter_value_reg(counter_value_reg), .status_reg(status_reg),
		.compare_output_flag(compare_output_flag), .irq_pending_reg(irq_pending_reg),
		.diag_alarm_on_reg(diag_alarm_on_reg));
	cpc_enc_model enc (.clk_sys(clk_sys), .fwd(fwd), .bwd(bwd), .trk_a(trk_a), .trk_b(trk_b));
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wr(input logic [3:0] s, input logic [31:0] d);
		@(negedge clk_sys);
		prm_wr = 1'b1;
		prm_slot = s;
		prm_wdata = d;
		@(negedge clk_sys);
		prm_wr = 1'b0;
	endtask
	task automatic rd(input logic [3:0] s, output logic [31:0] d);
		@(negedge clk_sys);
		prm_slot = s;
		idle(2);
		d = prm_rdata_reg;
	endtask
	task automatic pulse(input int b);
		@(negedge clk_sys);
		ctrl_word[b] = 1'b1;
		@(negedge clk_sys);
		ctrl_word[b] = 1'b0;
		idle(3);
	endtask
	// Gap between edges far above the filter time
	task automatic step(input logic up, input int n);
		repeat (n) begin
			@(negedge clk_sys);
			fwd = up;
			bwd = !up;
			@(negedge clk_sys);
			fwd = 1'b0;
			bwd = 1'b0;
			idle(14);
		end
		idle(10);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#200us;
		fail_count++;
		final_report();
	end
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		idle(8);
		reset = 1'b0;
		idle(4);
		foreach (rows[i]) begin
			rd(rows[i][67:64], v);
			check("reset value", v, (rows[i][67:64] inside {[4'h2:4'h4]}) ? 32'h2 : 32'h0);
			wr(rows[i][67:64], rows[i][63:32]);
			rd(rows[i][67:64], v);
			check("readback", v, rows[i][31:0]);
		end
		check("diag on", diag_alarm_on_reg, 32'h1);
		wr(4'h1, 32'h0);
		idle(1);
		check("diag off", diag_alarm_on_reg, 32'h0);
		wr(4'h7, 32'h0);
		wr(4'h8, 32'h1);
		wr(4'h9, 32'h83);
		wr(4'hC, 32'h0);
		set_value = 32'h7FFF_FFFE;
		pulse(1);
		pulse(2);
		pulse(5);
		check("set value", counter_value_reg, 32'h7FFF_FFFE);
		check("ge flag", compare_output_flag, 32'h1);
		step(1'b1, 3);
		check("wrap up", counter_value_reg, 32'h8000_0001);
		check("signed ge", compare_output_flag, 32'h0);
		check("ovf irq", irq_pending_reg[0], 32'h1);
		check("ovf sticky", status_reg[11], 32'h1);
		@(negedge clk_sys);
		irq_ack = 4'h1;
		@(negedge clk_sys);
		irq_ack = 4'h0;
		check("irq ack", irq_pending_reg[0], 32'h0);
		pulse(6);
		check("sticky clear", status_reg[11], 32'h0);
		pulse(10);
		wr(4'h8, 32'h19);
		pin_reset_in = 1'b1;
		idle(30);
		check("reset input off", counter_value_reg, 32'h8000_0001);
		pin_reset_in = 1'b0;
		idle(20);
		pulse(2);
		check("gate resume", counter_value_reg, 32'h8000_0001);
		step(1'b1, 2);
		check("inverted b", counter_value_reg, 32'h7FFF_FFFF);
		check("unf irq", irq_pending_reg[1], 32'h1);
		pulse(10);
		wr(4'h9, 32'h3);
		pulse(2);
		check("gate abort", counter_value_reg, 32'h1234);
		pulse(0);
		pin_reset_in = 1'b1;
		idle(30);
		check("reset input fired", status_reg[0], 32'h1);
		pin_reset_in = 1'b0;
		idle(20);
		pulse(10);
		wr(4'h9, 32'h0);
		pulse(2);
		v = counter_value_reg;
		step(1'b0, 2);
		check("counter off", counter_value_reg, v);
		// Once forward: load 1234h, end 1236h, so two edges reach the end
		pulse(10);
		wr(4'h7, 32'h1);
		wr(4'hA, 32'h1236);
		wr(4'h8, 32'h2);
		wr(4'h9, 32'h3);
		pulse(2);
		step(1'b1, 2);
		check("once end", counter_value_reg, 32'h1234);
		check("end irq", irq_pending_reg[3], 32'h1);
		check("end sticky", status_reg[10], 32'h1);
		check("le flag", compare_output_flag, 32'h0);
		step(1'b1, 1);
		check("once stop", counter_value_reg, 32'h1234);
		reset = 1'b1;
		idle(2);
		check("reset count", counter_value_reg, 32'h0);
		check("reset irq", irq_pending_reg, 32'h0);
		reset = 1'b0;
		idle(4);
		rd(4'h2, v);
		check("reset filter", v, 32'h2);
		final_report();
	end
endmodule // cpc_counter_tb_top
bind cpc_counter cpc_counter_properties chk_i (
	.clk_sys(clk_sys), .reset(reset), .prm_wr(prm_wr), .prm_slot(prm_slot),
	.prm_wdata(prm_wdata), .ctrl_word(ctrl_word), .irq_ack(irq_ack),
	.prm_rdata_reg(prm_rdata_reg), .status_reg(status_reg),
	.compare_output_flag(compare_output_flag), .irq_pending_reg(irq_pending_reg),
	.diag_alarm_on_reg(diag_alarm_on_reg));

// file: test/cpc_enc_model.sv
// Purpose: behavioural incremental encoder on tracks A and B
// Assumes: one request cycle gives one quadrature edge
// Notes: no bounce, so filter rejection is not exercised here
module cpc_enc_model (
	input wire clk_sys,
	input wire fwd,
	input wire bwd,
	output wire trk_a,
	output wire trk_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase_reg = 2'h0;
	// Gray order so track A leads track B when turning forward
	always_ff @(posedge clk_sys) begin
		if (fwd) begin
			phase_reg <= phase_reg + 2'h1;
		end else if (bwd) begin
			phase_reg <= phase_reg - 2'h1;
		end
	end
	assign trk_a = phase_reg[1] ^ phase_reg[0];
	assign trk_b = phase_reg[1];
endmodule // cpc_enc_model
